// [bench/board_strap_model.sv]
module board_strap_model #(
    parameter int REF_MHZ       = 100,
    parameter int FIFO_GMII_MHZ = 100,
    parameter int FIFO_ENC_MHZ  = 125
) (
    input  wire logic [3:0] plat_sel,
    input  wire logic [4:0] core_sel,
    output logic      [3:0] platform_ratio_strap,
    output logic      [4:0] core_ratio_strap,
    output logic      [7:0] ref_mhz,
    output logic      [7:0] fifo_gmii_mhz,
    output logic      [7:0] fifo_enc_mhz
);
    timeunit 1ns;
    timeprecision 1ps;

    // every strap pin is held at a full level by its resistor, none floats
    assign platform_ratio_strap = plat_sel;
    assign core_ratio_strap     = core_sel;
    // oscillator rate stays inside the allowed reference band
    assign ref_mhz              = 8'(REF_MHZ);
    // interface clocks offered on the FIFO ports, sized for a 500 MHz platform
    assign fifo_gmii_mhz        = 8'(FIFO_GMII_MHZ);
    assign fifo_enc_mhz         = 8'(FIFO_ENC_MHZ);
endmodule : board_strap_model

// [bench/clock_ratio_strap_decoder_bench.sv]
module clock_ratio_strap_decoder_bench;
    import clk_strap_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  plat_sel = 4'h2;
    logic [4:0]  core_sel = 5'h08;
    logic [3:0]  platform_ratio_strap;
    logic [4:0]  core_ratio_strap;
    logic [7:0]  ref_mhz;
    logic [7:0]  fifo_gmii_mhz;
    logic [7:0]  fifo_enc_mhz;
    ratio_s      ratio;
    logic        ratios_valid;
    logic        cfg_error;
    logic        mem_clk_en;
    logic        local_clk_en;
    logic        irq;
    int          num_errors = 0;
    int          comparisons = 0;
    logic [31:0] rd;
    logic        err;

    always #20 pclk = ~pclk;

    board_strap_model board_strap_model_inst (.plat_sel(plat_sel), .core_sel(core_sel),
        .platform_ratio_strap(platform_ratio_strap), .core_ratio_strap(core_ratio_strap), .ref_mhz(ref_mhz),
        .fifo_gmii_mhz(fifo_gmii_mhz), .fifo_enc_mhz(fifo_enc_mhz));

    clock_ratio_strap_decoder clock_ratio_strap_decoder_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .platform_ratio_strap(platform_ratio_strap), .core_ratio_strap(core_ratio_strap),
        .ratio(ratio), .ratios_valid(ratios_valid), .cfg_error(cfg_error), .mem_clk_en(mem_clk_en),
        .local_clk_en(local_clk_en), .irq(irq));

    function automatic logic [3:0] plat_mult_of(input logic [3:0] code);
        case (code)
            4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9: return code;
            default: return 4'h0;
        endcase
    endfunction : plat_mult_of

    function automatic logic [3:0] core_x2_of(input logic [4:0] code);
        case (code)
            5'h08: return 4'h4;
            5'h0c: return 4'h5;
            5'h10: return 4'h6;
            5'h1c: return 4'h7;
            5'h14: return 4'h8;
            5'h0e: return 4'h9;
            default: return 4'h0;
        endcase
    endfunction : core_x2_of

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expd);
        comparisons++;
        if (seen !== expd) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, expd, seen);
        end
    endtask : check

    // request held from setup until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] data, output logic slverr);
        bit done;
        done = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (int n = 0; n < 20 && !done; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                done = 1;
            end
        end
        data    = prdata;
        slverr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (!done) begin
            num_errors++;
            $display("[ERR] pready expected 1 seen timeout");
            test_done();
        end
    endtask : apb

    task automatic restart(input logic [3:0] p, input logic [4:0] c);
        @(posedge pclk);
        plat_sel <= p;
        core_sel <= c;
        presetn  <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn  <= 1'b1;
        repeat (6) @(posedge pclk);
    endtask : restart

    task automatic t_reset_regs();
        restart(4'h5, 5'h10);
        apb(1'b0, 12'h000, 32'h0, rd, err);
        check("ref_freq", rd, 32'h64);
        apb(1'b0, 12'h004, 32'h0, rd, err);
        check("lb_div", rd, 32'h8);
        apb(1'b0, 12'h008, 32'h0, rd, err);
        check("grade", rd, 32'h5dc);
        apb(1'b0, 12'h01c, 32'h0, rd, err);
        check("mask", rd, 32'h0);
        apb(1'b1, 12'h020, 32'hffff_ffff, rd, err);
        check("unmapped_err", {31'h0, err}, 32'h1);
        apb(1'b0, 12'h020, 32'h0, rd, err);
        check("unmapped_rd", {err, rd[30:0]}, 32'h8000_0000);
        apb(1'b1, 12'h00c, 32'h0, rd, err);
        apb(1'b0, 12'h00c, 32'h0, rd, err);
        check("ratios_ro", rd, 32'h8065_0705);
    endtask : t_reset_regs

    task automatic t_plat_decode();
        logic [3:0] pm;
        for (int i = 0; i < 16; i++) begin
            restart(4'(i), 5'h08);
            pm = plat_mult_of(4'(i));
            check("plat_mult", {28'h0, ratio.plat_mult}, {28'h0, pm});
            check("plat_ok", {31'h0, ratio.plat_ok}, {31'h0, pm != 4'h0});
            check("plat_cfg_err", {31'h0, cfg_error}, {31'h0, pm == 4'h0});
            check("valid", {31'h0, ratios_valid}, 32'h1);
        end
    endtask : t_plat_decode

    task automatic t_core_decode();
        logic [3:0] cx;
        for (int i = 0; i < 32; i++) begin
            restart(4'h2, 5'(i));
            cx = core_x2_of(5'(i));
            check("core_x2", {28'h0, ratio.core_x2}, {28'h0, cx});
            check("core_ok", {31'h0, ratio.core_ok}, {31'h0, cx != 4'h0});
            check("core_cfg_err", {31'h0, cfg_error}, {31'h0, cx == 4'h0});
        end
    endtask : t_core_decode

    task automatic t_freq_hold();
        int   pulses;
        logic prev;
        // 100 MHz reference at 5:1 gives a 500 MHz platform, the memory data rate
        restart(4'h5, 5'h10);
        apb(1'b1, 12'h000, {24'h0, ref_mhz}, rd, err);
        apb(1'b0, 12'h010, 32'h0, rd, err);
        check("freq_pc", rd, {16'd1500, 16'd500});
        check("fifo_gmii", {31'h0, 32'(fifo_gmii_mhz) * 42 <= 32'(rd[15:0]) * 10}, 32'h1);
        check("fifo_enc", {31'h0, 32'(fifo_enc_mhz) * 32 <= 32'(rd[15:0]) * 10}, 32'h1);
        apb(1'b0, 12'h014, 32'h0, rd, err);
        check("freq_ml", rd, {16'd62, 16'd250});
        prev = mem_clk_en;
        for (int n = 0; n < 8; n++) begin
            @(posedge pclk);
            check("mem_half", {31'h0, mem_clk_en}, {31'h0, ~prev});
            prev = mem_clk_en;
        end
        pulses = 0;
        for (int n = 0; n < 80; n++) begin
            @(posedge pclk);
            pulses += int'(local_clk_en === 1'b1);
        end
        check("lb_pulses", 32'(pulses), 32'd10);
        // divider 4 also drives the local clock spacing assertion
        apb(1'b1, 12'h004, 32'h4, rd, err);
        pulses = 0;
        for (int n = 0; n < 40; n++) begin
            @(posedge pclk);
            pulses += int'(local_clk_en === 1'b1);
        end
        check("lb_pulses_div4", 32'(pulses), 32'd10);
        // strap pins are shared, so later activity must not reach the ratios
        plat_sel <= 4'h2;
        core_sel <= 5'h00;
        repeat (10) @(posedge pclk);
        check("hold_ratio", {22'h0, ratio}, {22'h0, 4'h5, 4'h6, 2'b11});
        apb(1'b0, 12'h00c, 32'h0, rd, err);
        check("hold_reg", rd[8:0], 32'h105);
    endtask : t_freq_hold

    task automatic t_irq_ranges();
        restart(4'h5, 5'h10);
        apb(1'b0, 12'h018, 32'h0, rd, err);
        check("status_init", rd, 32'h40);
        apb(1'b1, 12'h01c, 32'h40, rd, err);
        repeat (3) @(posedge pclk);
        check("irq_on", {31'h0, irq}, 32'h1);
        apb(1'b1, 12'h018, 32'h40, rd, err);
        repeat (3) @(posedge pclk);
        check("irq_clr", {31'h0, irq}, 32'h0);
        apb(1'b1, 12'h000, 32'd90, rd, err);
        apb(1'b1, 12'h018, 32'h04, rd, err);
        apb(1'b0, 12'h018, 32'h0, rd, err);
        check("plat_gap", rd, 32'h04);
        check("irq_masked", {31'h0, irq}, 32'h0);
        apb(1'b1, 12'h01c, 32'h3f, rd, err);
        repeat (3) @(posedge pclk);
        check("irq_range", {31'h0, irq}, 32'h1);
        apb(1'b1, 12'h000, 32'd100, rd, err);
        apb(1'b1, 12'h018, 32'h7f, rd, err);
        repeat (3) @(posedge pclk);
        check("irq_gone", {31'h0, irq}, 32'h0);
        apb(1'b1, 12'h008, 32'd1333, rd, err);
        apb(1'b0, 12'h018, 32'h0, rd, err);
        check("core_grade", rd, 32'h08);
        apb(1'b1, 12'h008, 32'd1500, rd, err);
        apb(1'b1, 12'h000, 32'd66, rd, err);
        apb(1'b1, 12'h018, 32'h7f, rd, err);
        apb(1'b0, 12'h018, 32'h0, rd, err);
        check("mem_low", rd, 32'h14);
        apb(1'b1, 12'h000, 32'd100, rd, err);
        apb(1'b1, 12'h004, 32'h1, rd, err);
        apb(1'b1, 12'h018, 32'h7f, rd, err);
        apb(1'b0, 12'h018, 32'h0, rd, err);
        check("lb_fast", rd, 32'h20);
    endtask : t_irq_ranges

    initial begin
        t_reset_regs();
        t_plat_decode();
        t_core_decode();
        t_freq_hold();
        t_irq_ranges();
        test_done();
    end
endmodule : clock_ratio_strap_decoder_bench

// [design/clk_strap_params.svh]
`ifndef CLK_STRAP_PARAMS_SVH
`define CLK_STRAP_PARAMS_SVH

// register byte offsets
`define OFF_REF_FREQ   12'h000
`define OFF_LB_DIV     12'h004
`define OFF_GRADE      12'h008
`define OFF_RATIOS     12'h00c
`define OFF_FREQ_PC    12'h010
`define OFF_FREQ_ML    12'h014
`define OFF_STATUS     12'h018
`define OFF_MASK       12'h01c

// reset values: reference 100 MHz, divider 8, grade 1500 MHz
`define RST_REF_FREQ   8'h64
`define RST_LB_DIV     8'h08
`define RST_GRADE      16'h05dc

// platform ratio strap codes
`define PLAT_CODE_2    4'h2
`define PLAT_CODE_3    4'h3
`define PLAT_CODE_4    4'h4
`define PLAT_CODE_5    4'h5
`define PLAT_CODE_6    4'h6
`define PLAT_CODE_8    4'h8
`define PLAT_CODE_9    4'h9
`define PLAT_RSV_0     4'h0
`define PLAT_RSV_1     4'h1
`define PLAT_RSV_7     4'h7

// core ratio strap codes, multiplier kept as twice the ratio
`define CORE_CODE_20   5'h08
`define CORE_CODE_25   5'h0c
`define CORE_CODE_30   5'h10
`define CORE_CODE_35   5'h1c
`define CORE_CODE_40   5'h14
`define CORE_CODE_45   5'h0e

// frequency limits in MHz: 400, 500, 600, 800, 200, 300, 25, 133
`define PLAT_LOW       16'h0190
`define PLAT_BAND_LO   16'h01f4
`define PLAT_BAND_HI   16'h0258
`define CORE_MIN       16'h0320
`define MEM_MIN        16'h00c8
`define MEM_MAX        16'h012c
`define LB_MIN         16'h0019
`define LB_MAX         16'h0085

// status / mask bit positions
`define ST_PLAT_RSV    0
`define ST_CORE_UNSUP  1
`define ST_PLAT_RANGE  2
`define ST_CORE_RANGE  3
`define ST_MEM_RANGE   4
`define ST_LB_RANGE    5
`define ST_LATCHED     6
`define STATUS_W       7

// cycles between reset release and strap capture
`define SETTLE_CNT     2'h3
`define RATIOS_VALID_BIT 31

`endif

// [design/clk_strap_pkg.sv]
package clk_strap_pkg;

    typedef enum logic [0:0] {ST_SETTLE, ST_HELD} latch_state_e;

    typedef struct packed {
        logic [3:0] plat_mult;
        logic [3:0] core_x2;
        logic       plat_ok;
        logic       core_ok;
    } ratio_s;

    typedef struct packed {
        logic [15:0] plat;
        logic [15:0] core;
        logic [15:0] mem;
        logic [15:0] lb;
    } freq_s;

endpackage : clk_strap_pkg

// [design/clock_ratio_strap_decoder.sv]
`include "clk_strap_params.svh"

module clock_ratio_strap_decoder
    import clk_strap_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [3:0]  platform_ratio_strap,
    input  wire logic [4:0]  core_ratio_strap,
    output ratio_s           ratio,
    output logic             ratios_valid,
    output logic             cfg_error,
    output logic             mem_clk_en,
    output logic             local_clk_en,
    output logic             irq
);

    // straps come from board pins: two flops before use
    logic [3:0] plat_meta_r, plat_sync_r;
    logic [4:0] core_meta_r, core_sync_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            plat_meta_r <= 4'h0;
            plat_sync_r <= 4'h0;
            core_meta_r <= 5'h00;
            core_sync_r <= 5'h00;
        end else begin
            plat_meta_r <= platform_ratio_strap;
            plat_sync_r <= plat_meta_r;
            core_meta_r <= core_ratio_strap;
            core_sync_r <= core_meta_r;
        end
    end

    function automatic logic [4:0] plat_decode(input logic [3:0] code);
        plat_decode = 5'h00;
        case (code)
            `PLAT_CODE_2: plat_decode = {1'b1, 4'h2};
            `PLAT_CODE_3: plat_decode = {1'b1, 4'h3};
            `PLAT_CODE_4: plat_decode = {1'b1, 4'h4};
            `PLAT_CODE_5: plat_decode = {1'b1, 4'h5};
            `PLAT_CODE_6: plat_decode = {1'b1, 4'h6};
            `PLAT_CODE_8: plat_decode = {1'b1, 4'h8};
            `PLAT_CODE_9: plat_decode = {1'b1, 4'h9};
            // reserved codes and the rest give no multiplier
            default:      plat_decode = 5'h00;
        endcase
    endfunction : plat_decode

    function automatic logic [4:0] core_decode(input logic [4:0] code);
        core_decode = 5'h00;
        case (code)
            `CORE_CODE_20: core_decode = {1'b1, 4'h4};
            `CORE_CODE_25: core_decode = {1'b1, 4'h5};
            `CORE_CODE_30: core_decode = {1'b1, 4'h6};
            `CORE_CODE_35: core_decode = {1'b1, 4'h7};
            `CORE_CODE_40: core_decode = {1'b1, 4'h8};
            `CORE_CODE_45: core_decode = {1'b1, 4'h9};
            default:       core_decode = 5'h00;
        endcase
    endfunction : core_decode

    // strap capture: waits for the synchronisers to fill, then freezes
    latch_state_e state_r, state_nxt;
    logic [1:0]   settle_r, settle_nxt;
    logic [3:0]   strap_plat_r, strap_plat_nxt;
    logic [4:0]   strap_core_r, strap_core_nxt;
    ratio_s       ratio_r, ratio_nxt;
    logic         valid_r, valid_nxt;
    logic [4:0]   pd, cd;

    always_comb begin
        state_nxt      = state_r;
        settle_nxt     = settle_r;
        strap_plat_nxt = strap_plat_r;
        strap_core_nxt = strap_core_r;
        ratio_nxt      = ratio_r;
        valid_nxt      = valid_r;
        pd             = plat_decode(plat_sync_r);
        cd             = core_decode(core_sync_r);
        case (state_r)
            ST_SETTLE: begin
                if (settle_r == `SETTLE_CNT) begin
                    strap_plat_nxt = plat_sync_r;
                    strap_core_nxt = core_sync_r;
                    ratio_nxt      = '{plat_mult: pd[3:0], core_x2: cd[3:0],
                                       plat_ok: pd[4], core_ok: cd[4]};
                    valid_nxt      = 1'b1;
                    state_nxt      = ST_HELD;
                end else begin
                    settle_nxt = settle_r + 2'h1;
                end
            end
            ST_HELD: state_nxt = ST_HELD;
            default: state_nxt = ST_SETTLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r      <= ST_SETTLE;
            settle_r     <= 2'h0;
            strap_plat_r <= 4'h0;
            strap_core_r <= 5'h00;
            ratio_r      <= '0;
            valid_r      <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            settle_r     <= settle_nxt;
            strap_plat_r <= strap_plat_nxt;
            strap_core_r <= strap_core_nxt;
            ratio_r      <= ratio_nxt;
            valid_r      <= valid_nxt;
        end
    end

    // software registers
    logic [7:0]  ref_r, ref_nxt;
    logic [7:0]  div_r, div_nxt;
    logic [15:0] grade_r, grade_nxt;
    logic [`STATUS_W-1:0] mask_r, mask_nxt, status_r, status_nxt, ev;
    logic [31:0] prdata_r, prdata_nxt;
    logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic        wr_en;
    freq_s       f;

    // derived frequencies in MHz, from reference value software supplies
    always_comb begin
        f.plat = 16'(ref_r * ratio_r.plat_mult);
        f.core = 16'((32'(f.plat) * ratio_r.core_x2) >> 1);
        f.mem  = f.plat >> 1;
        f.lb   = (div_r == 8'h00) ? 16'h0000 : 16'(f.plat / div_r);
    end

    // range checks only mean something once ratios are frozen
    always_comb begin
        ev = '0;
        if (valid_r) begin
            ev[`ST_PLAT_RSV]   = !ratio_r.plat_ok;
            ev[`ST_CORE_UNSUP] = !ratio_r.core_ok;
            ev[`ST_PLAT_RANGE] = !(f.plat == `PLAT_LOW ||
                                   (f.plat >= `PLAT_BAND_LO && f.plat <= `PLAT_BAND_HI));
            ev[`ST_CORE_RANGE] = f.core < `CORE_MIN || f.core > grade_r;
            ev[`ST_MEM_RANGE]  = f.mem < `MEM_MIN || f.mem > `MEM_MAX;
            ev[`ST_LB_RANGE]   = f.lb < `LB_MIN || f.lb > `LB_MAX;
        end
        ev[`ST_LATCHED] = (state_r == ST_SETTLE) && valid_nxt;
    end

    // no wait state: pready rises in the first access cycle
    assign wr_en = psel && penable && pready_r && pwrite;

    always_comb begin
        ref_nxt     = ref_r;
        div_nxt     = div_r;
        grade_nxt   = grade_r;
        mask_nxt    = mask_r;
        prdata_nxt  = prdata_r;
        pslverr_nxt = pslverr_r;
        pready_nxt  = psel && !penable;
        if (psel && !penable) begin
            pslverr_nxt = 1'b0;
            prdata_nxt  = 32'h0000_0000;
            case (paddr)
                `OFF_REF_FREQ: prdata_nxt[7:0]  = ref_r;
                `OFF_LB_DIV:   prdata_nxt[7:0]  = div_r;
                `OFF_GRADE:    prdata_nxt[15:0] = grade_r;
                `OFF_RATIOS:   prdata_nxt = {valid_r, 7'h00, ratio_r.core_x2, ratio_r.plat_mult,
                                             5'h00, ratio_r.core_ok, ratio_r.plat_ok,
                                             strap_core_r, strap_plat_r};
                `OFF_FREQ_PC:  prdata_nxt = {f.core, f.plat};
                `OFF_FREQ_ML:  prdata_nxt = {f.lb, f.mem};
                `OFF_STATUS:   prdata_nxt[`STATUS_W-1:0] = status_r;
                `OFF_MASK:     prdata_nxt[`STATUS_W-1:0] = mask_r;
                default:       pslverr_nxt = 1'b1;
            endcase
        end
        if (wr_en) begin
            case (paddr)
                `OFF_REF_FREQ: ref_nxt   = pwdata[7:0];
                `OFF_LB_DIV:   div_nxt   = pwdata[7:0];
                `OFF_GRADE:    grade_nxt = pwdata[15:0];
                `OFF_MASK:     mask_nxt  = pwdata[`STATUS_W-1:0];
                default:       ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_r     <= `RST_REF_FREQ;
            div_r     <= `RST_LB_DIV;
            grade_r   <= `RST_GRADE;
            mask_r    <= '0;
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            ref_r     <= ref_nxt;
            div_r     <= div_nxt;
            grade_r   <= grade_nxt;
            mask_r    <= mask_nxt;
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // sticky status, write one to clear; a new event beats the clear
    logic irq_r, irq_nxt, cfg_err_r, cfg_err_nxt;

    always_comb begin
        status_nxt = status_r;
        if (wr_en && paddr == `OFF_STATUS) begin
            status_nxt = status_r & ~pwdata[`STATUS_W-1:0];
        end
        status_nxt  = status_nxt | ev;
        irq_nxt     = |(status_nxt & mask_nxt);
        cfg_err_nxt = valid_nxt && !(ratio_nxt.plat_ok && ratio_nxt.core_ok);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r  <= '0;
            irq_r     <= 1'b0;
            cfg_err_r <= 1'b0;
        end else begin
            status_r  <= status_nxt;
            irq_r     <= irq_nxt;
            cfg_err_r <= cfg_err_nxt;
        end
    end

    // clock enables: pclk stands in for the platform clock
    logic       mem_en_r, mem_en_nxt, lb_en_r, lb_en_nxt;
    logic [7:0] lb_cnt_r, lb_cnt_nxt;

    always_comb begin
        mem_en_nxt = valid_r && !mem_en_r;
        lb_cnt_nxt = lb_cnt_r;
        lb_en_nxt  = 1'b0;
        // divider zero stalls the local clock rather than dividing by zero
        if (valid_r && div_r != 8'h00) begin
            if (lb_cnt_r >= div_r - 8'h01) begin
                lb_cnt_nxt = 8'h00;
                lb_en_nxt  = 1'b1;
            end else begin
                lb_cnt_nxt = lb_cnt_r + 8'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_en_r <= 1'b0;
            lb_en_r  <= 1'b0;
            lb_cnt_r <= 8'h00;
        end else begin
            mem_en_r <= mem_en_nxt;
            lb_en_r  <= lb_en_nxt;
            lb_cnt_r <= lb_cnt_nxt;
        end
    end

    assign prdata       = prdata_r;
    assign pready       = pready_r;
    assign pslverr      = pslverr_r;
    assign ratio        = ratio_r;
    assign ratios_valid = valid_r;
    assign cfg_error    = cfg_err_r;
    assign mem_clk_en   = mem_en_r;
    assign local_clk_en = lb_en_r;
    assign irq          = irq_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence mem_pulse_pair;
        mem_en_r ##1 !mem_en_r ##1 mem_en_r;
    endsequence

    plat_nine_a: assert property (valid_r && strap_plat_r == `PLAT_CODE_9 |-> ratio_r.plat_mult == 4'h9)
        else $error("platform code 1001 not decoded as 9");
    plat_rsv_a: assert property (valid_r && (strap_plat_r == `PLAT_RSV_0 || strap_plat_r == `PLAT_RSV_7)
        |-> !ratio_r.plat_ok ##1 cfg_err_r && status_r[`ST_PLAT_RSV])
        else $error("reserved platform code accepted");
    core_half_a: assert property (valid_r && strap_core_r == `CORE_CODE_45 |-> ratio_r.core_x2 == 4'h9)
        else $error("core code 01110 not decoded as 4.5");
    core_unsup_a: assert property (valid_r && !ratio_r.core_ok |-> ##[0:1] status_r[`ST_CORE_UNSUP])
        else $error("unsupported core code not flagged");
    mem_half_a: assert property (valid_r && mem_en_r |-> mem_pulse_pair)
        else $error("memory enable not at half rate");
    plat_gap_a: assert property (valid_r && f.plat > `PLAT_LOW && f.plat < `PLAT_BAND_LO
        |=> status_r[`ST_PLAT_RANGE])
        else $error("platform frequency in gap not flagged");
    lb_spacing_a: assert property (lb_en_r && div_r == 8'h04 && $stable(div_r) |=> !lb_en_r [*3] ##1 lb_en_r)
        else $error("local clock spacing wrong for divider 4");
    core_grade_a: assert property (valid_r && f.core > grade_r |=> status_r[`ST_CORE_RANGE])
        else $error("core above speed grade not flagged");
    mem_range_a: assert property (valid_r && (f.mem > `MEM_MAX || f.mem < `MEM_MIN) |=> status_r[`ST_MEM_RANGE])
        else $error("memory clock out of range not flagged");
    ratio_hold_a: assert property (valid_r |=> valid_r && $stable(ratio_r) && $stable(strap_plat_r))
        else $error("latched ratios changed");

endmodule : clock_ratio_strap_decoder
